// *** rtl/dcs_drive_ctrl.sv ***
// Fieldbus command word interpreter and status word builder of a motor drive
`timescale 1ns/1ns

// Notes on behaviour
// - Command bit 0 set runs the motor; clear gives a normal stop.
// - Command bit 1 set gives a fast stop, which overrides bit 0.
// - Command bit 2 set while tripped clears the trip.
// - Command bit 3 set gives a coast stop with drive removed.
// - Priority among motion bits: coast, then fast stop, then run.
// - Motion bits act only when start source is 0 or 1; else terminals.
// - Reset bit always honoured when control source is 3 or 4.
// - Speed setpoint is unsigned, in tenths of a hertz.
// - Accepted speed setpoint is clamped to the maximum speed setting.
// - Ramp duration applies only while control source equals 4.
// - One ramp value loads acceleration and deceleration together.
// - Ramp duration is in hundredths of a second.
// - Status high byte holds the fault code, meaningful only when tripped.
// - Status bit 0 shows running, bit 1 shows tripped.
// - Status bit 5 shows standby.
// - Status bit 6 shows ready: not tripped, enabled, no mains loss.
module dcs_drive_ctrl #(
  parameter int DATA_W = 16
) (
  // Clock and reset
  input  wire logic                  clock,
  input  wire logic                  arst_n,
  // Fieldbus register port
  input  wire logic                  wrStrobe,
  input  wire logic [3:0]            wrIndex,
  input  wire logic [DATA_W-1:0]     wrData,
  input  wire logic [3:0]            rdIndex,
  output logic      [DATA_W-1:0]     rdData,
  // Drive settings from the parameter store
  input  wire logic [3:0]            controlSource,
  input  wire logic [3:0]            startSource,
  input  wire logic [DATA_W-1:0]     maxSpeed,
  // Control terminals and supply monitor
  input  wire dcs_pkg::dcs_pins_t    pinsAsync,
  // Drive core state
  input  wire dcs_pkg::dcs_core_t    coreState,
  // Commands to the drive core
  output dcs_pkg::dcs_motion_t       motion,
  output logic                       tripClear,
  output logic      [DATA_W-1:0]     speedTarget,
  output logic      [DATA_W-1:0]     accelTime,
  output logic      [DATA_W-1:0]     decelTime
);

  // ****************************************
  // Elaboration checks
  // ****************************************
  if (DATA_W != 16) begin : gWidthCheck
    $error("DATA_W must be 16: the status word packs two bytes");
  end

  // ****************************************
  // Helpers
  // ****************************************
  function automatic dcs_pkg::dcs_motion_t resolveMotion(input logic runReq,
                                                         input logic fastReq,
                                                         input logic coastReq);
    dcs_pkg::dcs_motion_t m;
    if (coastReq) begin
      m = dcs_pkg::MOT_COAST;
    end else if (fastReq) begin
      m = dcs_pkg::MOT_FAST_STOP;
    end else if (runReq) begin
      m = dcs_pkg::MOT_RUN;
    end else begin
      m = dcs_pkg::MOT_STOP;
    end
    return m;
  endfunction

  function automatic logic isFieldbusCtrl(input logic [3:0] src);
    return (src == dcs_pkg::CTRL_SRC_BUS) || (src == dcs_pkg::CTRL_SRC_BUS_RMP);
  endfunction

  // Write decode shared by every writable register
  function automatic logic wrHits(input logic       strobe,
                                  input logic [3:0] idx,
                                  input logic [3:0] target);
    return strobe && (idx == target);
  endfunction

  // ****************************************
  // Reset release
  // ****************************************
  logic [1:0] rstSync_r;
  logic       rst_n;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rstSync_r <= 2'b00;
    end else begin
      rstSync_r <= {rstSync_r[0], 1'b1};
    end
  end
  assign rst_n = rstSync_r[1];

  // ****************************************
  // Pin synchronisers
  // ****************************************
  dcs_pkg::dcs_pins_t pinsMeta_r;
  dcs_pkg::dcs_pins_t pins_r;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pinsMeta_r <= '0;
      pins_r     <= '0;
    end else begin
      pinsMeta_r <= pinsAsync;
      pins_r     <= pinsMeta_r;
    end
  end

  // ****************************************
  // Writable registers
  // ****************************************
  logic [DATA_W-1:0] command_word_r;
  logic [DATA_W-1:0] speed_setpoint_r;
  logic [DATA_W-1:0] ramp_duration_r;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      command_word_r <= dcs_pkg::COMMAND_RESET;
    end else if (wrHits(wrStrobe, wrIndex, dcs_pkg::REG_COMMAND_WORD)) begin
      command_word_r <= wrData;
    end
  end

  // Both speed registers land in one setpoint; the last write wins
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      speed_setpoint_r <= dcs_pkg::SPEED_RESET;
    end else if (wrHits(wrStrobe, wrIndex, dcs_pkg::REG_SPEED_SETPOINT) ||
                 wrHits(wrStrobe, wrIndex, dcs_pkg::REG_SPEED_ALT)) begin
      speed_setpoint_r <= wrData;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ramp_duration_r <= dcs_pkg::RAMP_RESET;
    end else if (wrHits(wrStrobe, wrIndex, dcs_pkg::REG_RAMP_DURATION)) begin
      ramp_duration_r <= wrData;
    end
  end

  // ****************************************
  // Motion command
  // ****************************************
  logic                 busStarts;
  dcs_pkg::dcs_motion_t motion_nxt;

  assign busStarts = (startSource == dcs_pkg::START_SRC_BUS_A) ||
                     (startSource == dcs_pkg::START_SRC_BUS_B);

  always_comb begin
    if (busStarts) begin
      motion_nxt = resolveMotion(command_word_r[dcs_pkg::CMD_RUN_BIT],
                                 command_word_r[dcs_pkg::CMD_FAST_BIT],
                                 command_word_r[dcs_pkg::CMD_COAST_BIT]);
    end else begin
      motion_nxt = resolveMotion(pins_r.run, pins_r.fastStop, pins_r.coast);
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      motion <= dcs_pkg::MOT_STOP;
    end else begin
      motion <= motion_nxt;
    end
  end

  // ****************************************
  // Trip clear
  // ****************************************
  // Held as a level while asked and tripped; if the master leaves the bit
  // set, a later trip is cleared at once, which is why it must drop it.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tripClear <= 1'b0;
    end else begin
      tripClear <= command_word_r[dcs_pkg::CMD_RESET_BIT] && coreState.tripped &&
                   isFieldbusCtrl(controlSource);
    end
  end

  // ****************************************
  // Speed target and ramps
  // ****************************************
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      speedTarget <= dcs_pkg::SPEED_RESET;
    end else if (speed_setpoint_r > maxSpeed) begin
      speedTarget <= maxSpeed;
    end else begin
      speedTarget <= speed_setpoint_r;
    end
  end

  // Outside ramp mode the ramps keep whatever they last held
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      accelTime <= dcs_pkg::RAMP_RESET;
      decelTime <= dcs_pkg::RAMP_RESET;
    end else if (controlSource == dcs_pkg::CTRL_SRC_BUS_RMP) begin
      accelTime <= ramp_duration_r;
      decelTime <= ramp_duration_r;
    end
  end

  // ****************************************
  // Status word and read-back
  // ****************************************
  logic [DATA_W-1:0] state_and_fault_word;

  always_comb begin
    state_and_fault_word = '0;
    state_and_fault_word[dcs_pkg::STS_RUNNING_BIT] = coreState.running;
    state_and_fault_word[dcs_pkg::STS_TRIPPED_BIT] = coreState.tripped;
    state_and_fault_word[dcs_pkg::STS_STANDBY_BIT] = coreState.standby;
    state_and_fault_word[dcs_pkg::STS_READY_BIT]   = !coreState.tripped &&
                                                     pins_r.hwEnable &&
                                                     !pins_r.mainsLoss;
    if (coreState.tripped) begin
      state_and_fault_word[dcs_pkg::STS_FAULT_LSB +: 8] = coreState.faultCode;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdData <= '0;
    end else begin
      case (rdIndex)
        dcs_pkg::REG_COMMAND_WORD:   rdData <= command_word_r;
        dcs_pkg::REG_SPEED_SETPOINT: rdData <= speed_setpoint_r;
        dcs_pkg::REG_SPEED_ALT:      rdData <= speed_setpoint_r;
        dcs_pkg::REG_RAMP_DURATION:  rdData <= ramp_duration_r;
        dcs_pkg::REG_STATE_FAULT:    rdData <= state_and_fault_word;
        default:                     rdData <= '0;
      endcase
    end
  end

endmodule

// *** rtl/dcs_pkg.sv ***
// Constants and types shared by the drive command and status logic
package dcs_pkg;

  // ****************************************
  // Register numbers on the fieldbus register port
  // ****************************************
  localparam logic [3:0] REG_COMMAND_WORD   = 4'h1;
  localparam logic [3:0] REG_SPEED_SETPOINT = 4'h2;
  localparam logic [3:0] REG_RAMP_DURATION  = 4'h4;
  localparam logic [3:0] REG_SPEED_ALT      = 4'h5;
  localparam logic [3:0] REG_STATE_FAULT    = 4'h6;

  // ****************************************
  // Command word bit positions
  // ****************************************
  localparam int CMD_RUN_BIT   = 0;
  localparam int CMD_FAST_BIT  = 1;
  localparam int CMD_RESET_BIT = 2;
  localparam int CMD_COAST_BIT = 3;

  // ****************************************
  // Status word bit positions
  // ****************************************
  localparam int STS_RUNNING_BIT = 0;
  localparam int STS_TRIPPED_BIT = 1;
  localparam int STS_STANDBY_BIT = 5;
  localparam int STS_READY_BIT   = 6;
  localparam int STS_FAULT_LSB   = 8;

  // ****************************************
  // Mode selector values, reset values and synchroniser depth
  // ****************************************
  localparam logic [3:0]  START_SRC_BUS_A  = 4'h0;
  localparam logic [3:0]  START_SRC_BUS_B  = 4'h1;
  localparam logic [3:0]  CTRL_SRC_BUS     = 4'h3;
  localparam logic [3:0]  CTRL_SRC_BUS_RMP = 4'h4;
  localparam logic [15:0] COMMAND_RESET    = 16'h0000;
  localparam logic [15:0] SPEED_RESET      = 16'h0000;
  localparam logic [15:0] RAMP_RESET       = 16'h01F4;
  localparam int          SYNC_STAGES      = 2;

  // Resolved motion request
  typedef enum logic [1:0] {
    MOT_STOP,
    MOT_RUN,
    MOT_FAST_STOP,
    MOT_COAST
  } dcs_motion_t;

  // Terminal inputs that travel together
  typedef struct packed {
    logic run;
    logic fastStop;
    logic coast;
    logic hwEnable;
    logic mainsLoss;
  } dcs_pins_t;

  // Drive core state reported back
  typedef struct packed {
    logic       running;
    logic       tripped;
    logic       standby;
    logic [7:0] faultCode;
  } dcs_core_t;

endpackage

// *** testbench/dcs_bus_master.sv ***
// Fieldbus master model issuing register writes
`timescale 1ns/1ns
module dcs_bus_master (
  // Clock
  input wire logic     clock,
  // Write port toward the drive
  output logic         wrStrobe,
  output logic [3:0]   wrIndex,
  output logic [15:0]  wrData
);
  initial begin
    wrStrobe = 1'b0;
    wrIndex  = 4'h0;
    wrData   = 16'h0000;
  end
  // One-cycle pulse; released lines show the inverse so stale values cannot pass
  task automatic wr(input logic [3:0] idx, input logic [15:0] dat);
    @(negedge clock);
    wrStrobe = 1'b1;
    wrIndex  = idx;
    wrData   = dat;
    @(negedge clock);
    wrStrobe = 1'b0;
    wrIndex  = ~idx;
    wrData   = ~dat;
  endtask
endmodule

// *** testbench/dcs_drive_ctrl_sva.sv ***
// Assertion checker for the drive command and status logic
`timescale 1ns/1ns
module dcs_drive_ctrl_sva (
  // Clock and reset
  input wire logic                 clock,
  input wire logic                 arst_n,
  // Register port
  input wire logic                 wrStrobe,
  input wire logic [3:0]           wrIndex,
  input wire logic [15:0]          wrData,
  input wire logic [3:0]           rdIndex,
  input wire logic [15:0]          rdData,
  // Settings and core state
  input wire logic [3:0]           controlSource,
  input wire logic [3:0]           startSource,
  input wire logic [15:0]          maxSpeed,
  input wire dcs_pkg::dcs_core_t   coreState,
  // Commands to the core
  input wire dcs_pkg::dcs_motion_t motion,
  input wire logic                 tripClear,
  input wire logic [15:0]          speedTarget,
  input wire logic [15:0]          accelTime,
  input wire logic [15:0]          decelTime
);
  logic [1:0] liveCnt_r;
  logic       busSt;
  logic       cmdWr;
  // Internal reset lags the pin by two edges, so stay quiet for three edges
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      liveCnt_r <= 2'h0;
    end else if (liveCnt_r != 2'h3) begin
      liveCnt_r <= liveCnt_r + 2'h1;
    end
  end
  assign busSt = startSource < 4'h2;
  assign cmdWr = wrStrobe && wrIndex == dcs_pkg::REG_COMMAND_WORD && busSt;
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n || liveCnt_r != 2'h3);
  chk_coast_first: assert property (cmdWr && wrData[3] ##1 busSt |=>
    motion == dcs_pkg::MOT_COAST) else $error("coast not taken");
  chk_fast_over_run: assert property (cmdWr && wrData[3:1] == 3'h1 ##1 busSt |=>
    motion == dcs_pkg::MOT_FAST_STOP) else $error("fast stop not taken");
  chk_run_or_stop: assert property (cmdWr && !wrData[3] && !wrData[1] ##1 busSt |=>
    motion == ($past(wrData[0], 2) ? dcs_pkg::MOT_RUN : dcs_pkg::MOT_STOP))
    else $error("run or stop wrong");
  chk_trip_gate: assert property (tripClear |-> $past(coreState.tripped) &&
    $past(controlSource) inside {4'h3, 4'h4}) else $error("trip clear ungated");
  chk_speed_clamp: assert property (speedTarget <= $past(maxSpeed))
    else $error("speed above maximum");
  chk_ramp_pair: assert property (accelTime == decelTime)
    else $error("ramps differ");
  chk_ramp_hold: assert property ($past(controlSource) != 4'h4 |-> $stable(accelTime))
    else $error("ramp changed outside mode");
  chk_status_low: assert property (rdIndex == dcs_pkg::REG_STATE_FAULT |=>
    rdData[4:2] == 3'h0 && !rdData[7] && rdData[5] == $past(coreState.standby) &&
    rdData[1:0] == {$past(coreState.tripped), $past(coreState.running)})
    else $error("status low byte wrong");
  chk_fault_byte: assert property (rdIndex == dcs_pkg::REG_STATE_FAULT |=> rdData[15:8] ==
    ($past(coreState.tripped) ? $past(coreState.faultCode) : 8'h00)) else $error("fault byte");
  cover property (motion == dcs_pkg::MOT_COAST);
  cover property (tripClear);
  cover property (accelTime != 16'h01F4);
endmodule

// *** testbench/dcs_drive_ctrl_tb_top.sv ***
// Self-checking bench for the drive command and status logic
`timescale 1ns/1ns
module dcs_drive_ctrl_tb_top;
  logic clock = 1'b0, arst_n = 1'b0, look = 1'b0, wrStrobe, tripClear;
  logic [3:0] wrIndex, rdIndex = 4'h0, controlSource = 4'h3, startSource = 4'h0;
  logic [15:0] wrData, rdData, maxSpeed = 16'hFFFF, speedTarget, accelTime, decelTime, v, s;
  dcs_pkg::dcs_pins_t pinsAsync = 5'h02;
  dcs_pkg::dcs_core_t coreState = 11'h000;
  dcs_pkg::dcs_motion_t motion;
  logic [18:0] q[$];
  int num_errors = 0, checks = 0, i;
  dcs_drive_ctrl i_dcs_drive_ctrl (
    .clock(clock), .arst_n(arst_n), .wrStrobe(wrStrobe), .wrIndex(wrIndex), .wrData(wrData),
    .rdIndex(rdIndex), .rdData(rdData), .controlSource(controlSource),
    .startSource(startSource), .maxSpeed(maxSpeed), .pinsAsync(pinsAsync),
    .coreState(coreState), .motion(motion), .tripClear(tripClear),
    .speedTarget(speedTarget), .accelTime(accelTime), .decelTime(decelTime)
  );
  dcs_bus_master i_dcs_bus_master (
    .clock(clock), .wrStrobe(wrStrobe), .wrIndex(wrIndex), .wrData(wrData)
  );
  always #10 clock = ~clock;
  function automatic dcs_pkg::dcs_motion_t pri(input logic [3:0] b);
    return b[3] ? dcs_pkg::MOT_COAST : b[1] ? dcs_pkg::MOT_FAST_STOP :
      b[0] ? dcs_pkg::MOT_RUN : dcs_pkg::MOT_STOP;
  endfunction
  task automatic cmp_word(input logic [15:0] a, input logic [15:0] e);
    checks++;
    if (a !== e) begin
      num_errors++;
      $display("BAD %0t word %h expected %h", $time, a, e);
    end
  endtask
  task automatic cmp_motion(input dcs_pkg::dcs_motion_t a, input dcs_pkg::dcs_motion_t e);
    checks++;
    if (a !== e) begin
      num_errors++;
      $display("BAD %0t motion %0d expected %0d", $time, a, e);
    end
  endtask
  // Outputs settle within four cycles; the monitor compares one cycle later
  task automatic note(input logic [2:0] w, input logic [15:0] e);
    repeat (4) @(negedge clock);
    q.push_back({w, e});
    look <= 1'b1;
    @(negedge clock);
    look <= 1'b0;
  endtask
  always @(negedge clock) begin
    if (look) begin
      v = q[0][15:0];
      case (q[0][18:16])
        3'h1: cmp_motion(motion, dcs_pkg::dcs_motion_t'(v[1:0]));
        3'h2: cmp_word({15'h0000, tripClear}, v);
        3'h3: cmp_word(speedTarget, v);
        3'h4: cmp_word(accelTime, v);
        3'h5: cmp_word(decelTime, v);
        default: cmp_word(rdData, v);
      endcase
      void'(q.pop_front());
    end
  end
  task automatic finish_test();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (9000) @(posedge clock);
    num_errors++;
    $display("BAD %0t run too long", $time);
    finish_test();
  end
  initial begin
    void'($urandom(32'hB315));
    repeat (3) @(negedge clock);
    arst_n = 1'b1;
    repeat (3) @(negedge clock);
    rdIndex = dcs_pkg::REG_RAMP_DURATION;
    note(3'h0, 16'h01F4);
    $display("test reset done");
    for (i = 0; i < 32; i++) begin
      startSource = i[4] ? dcs_pkg::START_SRC_BUS_B : dcs_pkg::START_SRC_BUS_A;
      i_dcs_bus_master.wr(dcs_pkg::REG_COMMAND_WORD, {12'h000, 4'(i)});
      note(3'h1, {14'h0000, pri(4'(i))});
    end
    startSource = 4'h2;
    i_dcs_bus_master.wr(dcs_pkg::REG_COMMAND_WORD, 16'h0008);
    for (i = 0; i < 6; i++) begin
      pinsAsync = 5'($urandom());
      note(3'h1, {14'h0000, pri({pinsAsync.coast, 1'b0, pinsAsync.fastStop, pinsAsync.run})});
    end
    $display("test motion done");
    for (i = 0; i < 6; i++) begin
      maxSpeed = 16'($urandom_range(1000));
      s = (i == 0) ? 16'h00C8 : 16'($urandom_range(2000));
      i_dcs_bus_master.wr(dcs_pkg::REG_SPEED_SETPOINT, s);
      note(3'h3, (s < maxSpeed) ? s : maxSpeed);
    end
    i_dcs_bus_master.wr(dcs_pkg::REG_RAMP_DURATION, 16'h03E8);
    note(3'h4, 16'h01F4);
    note(3'h0, 16'h03E8);
    controlSource = dcs_pkg::CTRL_SRC_BUS_RMP;
    note(3'h4, 16'h03E8);
    note(3'h5, 16'h03E8);
    $display("test speed and ramp done");
    pinsAsync = 5'h02;
    coreState = 11'h25A;
    i_dcs_bus_master.wr(dcs_pkg::REG_COMMAND_WORD, 16'h0004);
    note(3'h2, 16'h0001);
    rdIndex = dcs_pkg::REG_STATE_FAULT;
    note(3'h0, 16'h5A02);
    controlSource = 4'h2;
    note(3'h2, 16'h0000);
    i_dcs_bus_master.wr(dcs_pkg::REG_COMMAND_WORD, 16'h0000);
    coreState = 11'h5A5;
    note(3'h0, 16'h0061);
    pinsAsync = 5'h03;
    note(3'h0, 16'h0021);
    i_dcs_bus_master.wr(4'hF, 16'hFFFF);
    rdIndex = 4'hF;
    note(3'h0, 16'h0000);
    $display("test status done");
    arst_n = 1'b0;
    repeat (3) @(negedge clock);
    arst_n = 1'b1;
    repeat (3) @(negedge clock);
    note(3'h4, 16'h01F4);
    note(3'h5, 16'h01F4);
    maxSpeed = 16'h03E8;
    rdIndex = dcs_pkg::REG_SPEED_SETPOINT;
    i_dcs_bus_master.wr(dcs_pkg::REG_SPEED_ALT, 16'h07D0);
    note(3'h3, 16'h03E8);
    note(3'h0, 16'h07D0);
    $display("test reset and alternate speed done");
    finish_test();
  end
endmodule
bind dcs_drive_ctrl dcs_drive_ctrl_sva i_dcs_drive_ctrl_sva (
  .clock(clock), .arst_n(arst_n), .wrStrobe(wrStrobe), .wrIndex(wrIndex), .wrData(wrData),
  .rdIndex(rdIndex), .rdData(rdData), .controlSource(controlSource),
  .startSource(startSource), .maxSpeed(maxSpeed), .coreState(coreState),
  .motion(motion), .tripClear(tripClear), .speedTarget(speedTarget),
  .accelTime(accelTime), .decelTime(decelTime)
);
